// ### core/mac_ctrl_pkg.sv
// Constants shared by the receive filter, pad trimmer and retry control.
package mac_ctrl_pkg;

    // Register byte offsets.
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_ADDR_HI = 8'h04;
    localparam logic [7:0] OFF_ADDR_LO = 8'h08;
    localparam logic [7:0] OFF_HASH_HI = 8'h0C;
    localparam logic [7:0] OFF_HASH_LO = 8'h10;
    localparam logic [7:0] OFF_WAKE = 8'h14;
    localparam logic [7:0] OFF_INT_STAT = 8'h18;
    localparam logic [7:0] OFF_INT_MASK = 8'h1C;
    localparam logic [7:0] OFF_TX_STAT = 8'h20;

    // Control and wake register field positions.
    localparam int BIT_PROMISC = 18;
    localparam int BIT_ACCEPT_BAD = 16;
    localparam int BIT_HASH_ONLY = 15;
    localparam int BIT_HASH_PERF = 13;
    localparam int BIT_BROADCAST_DISABLE_DIS = 11;
    localparam int BIT_RETRY_DIS = 10;
    localparam int BIT_PAD_STRIP = 8;
    localparam int BIT_WAKE_EN = 0;

    // Reset values and writable masks.
    localparam logic [31:0] CTRL_RST = 32'h0004_0000;
    localparam logic [31:0] CTRL_WMASK = 32'h0005_AD00;
    localparam logic [31:0] ADDR_HI_WMASK = 32'h0000_FFFF;
    localparam logic [31:0] WAKE_WMASK = 32'h0000_0001;
    localparam logic [31:0] ZERO_RST = 32'h0000_0000;

    // Interrupt status bits.
    localparam int INT_W = 3;
    localparam int INT_RX_ACCEPT = 0;
    localparam int INT_RX_REJECT = 1;
    localparam int INT_TX_RETRY_ERR = 2;

    // Frame layout and retry counts.
    localparam logic [11:0] DA_BYTES = 12'h006;
    localparam logic [11:0] LEN_HI_IDX = 12'h00C;
    localparam logic [11:0] LEN_LO_IDX = 12'h00D;
    localparam logic [15:0] MIN_LEN = 16'h002E;
    localparam logic [11:0] IDX_MAX = 12'hFFF;
    localparam logic [4:0] MAX_ATTEMPTS = 5'h10;
    localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
    localparam logic [31:0] CRC_POLY = 32'hEDB8_8320;

    // Receive and transmit state machines.
    typedef enum logic [1:0] {
        RX_PASS = 2'b01,
        RX_TRIM = 2'b10
    } rx_state_e;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_ACTIVE = 2'b10
    } tx_state_e;

    // Advances a reflected CRC-32 over one byte, low bit first.
    function automatic logic [31:0] crc32_byte(input logic [31:0] crc,
                                               input logic [7:0] data);
        logic [31:0] c;
        c = crc;
        for (int i = 0; i < 8; i++) begin
            if (c[0] ^ data[i]) begin
                c = (c >> 1) ^ CRC_POLY;
            end else begin
                c = c >> 1;
            end
        end
        return c;
    endfunction : crc32_byte

endpackage : mac_ctrl_pkg

// ### core/addr_check.sv
// Destination address checker for perfect and hash filtering.
`timescale 1ns/10ps
module addr_check
    import mac_ctrl_pkg::*;
(
    // Frame destination and hash index.
    input wire logic [47:0] dest_addr_i,
    input wire logic [5:0] hash_idx_i,
    // Programmed filter state.
    input wire logic [47:0] station_addr_i,
    input wire logic [63:0] hash_table_i,
    input wire logic hash_perfect_select_i,
    input wire logic hash_only_filter_i,
    // Results.
    output logic addr_pass_o,
    output logic is_broadcast_disable_o,
    output logic hash_hit_o
);

    logic mcast;
    logic perfect;

    assign is_broadcast_disable_o = &dest_addr_i;
    assign mcast = dest_addr_i[0] & ~is_broadcast_disable_o;
    assign perfect = (dest_addr_i == station_addr_i);
    assign hash_hit_o = hash_table_i[hash_idx_i];

    // Multicast uses the hash table in either hash mode, individual only
    // in hash-only mode.
    always_comb begin
        if (hash_only_filter_i) begin
            addr_pass_o = hash_hit_o;
        end else if (hash_perfect_select_i && mcast) begin
            addr_pass_o = hash_hit_o;
        end else begin
            addr_pass_o = perfect;
        end
    end

endmodule : addr_check

// ### core/mac_rx_tx_ctrl.sv
// Receive filter, pad trimmer, retry control and their registers.
`timescale 1ns/10ps
// Functional notes
// - Accept-bad-frames passes runts and collided frames.
// - Hash-only hashes individual and multicast addresses.
// - Select and hash-only clear: perfect match against station address.
// - Select set: multicast filtered by hash table.
// - Select set: individual hashed only if hash-only.
// - Broadcast-disable rejects broadcasts; clear forwards all.
// - Enabled wake-up broadcast frame passes despite broadcast-disable.
// - Retry-disable: one attempt, drop, flag retry error.
// - Otherwise sixteen attempts before retry error.
// - Pad strip, length under 46: drop pad, FCS.
// - Pad strip, length 46 or more: unchanged.
// - Pad strip off: every frame unchanged.
// - Promiscuous accepts any destination; set after reset.
module mac_rx_tx_ctrl
    import mac_ctrl_pkg::*;
(
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Register port.
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rd_data_o,
    // Receive byte stream from the fabric port.
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_last_i,
    input wire logic rx_bad_i,
    input wire logic rx_wakeup_i,
    // Receive byte stream to the host.
    output logic rx_out_valid_o,
    output logic [7:0] rx_out_data_o,
    output logic rx_out_last_o,
    output logic rx_frame_done_o,
    output logic rx_frame_accept_o,
    // Transmit attempt control.
    input wire logic tx_start_i,
    input wire logic tx_collision_i,
    input wire logic tx_success_i,
    output logic tx_retry_o,
    output logic tx_abandon_o,
    output logic tx_retry_err_o,
    // Interrupt.
    output logic irq_o
);

    logic [31:0] ctrl_q;
    logic [31:0] addr_hi_q;
    logic [31:0] addr_lo_q;
    logic [31:0] hash_hi_q;
    logic [31:0] hash_lo_q;
    logic [31:0] wake_q;
    logic [INT_W-1:0] int_stat_q;
    logic [INT_W-1:0] int_mask_q;
    logic [31:0] rd_data_d;
    logic [INT_W-1:0] int_evt;
    logic [INT_W-1:0] int_clr;

    logic promisc;
    logic accept_bad;
    logic broadcast_disable_dis;
    logic retry_dis;
    logic pad_strip;
    logic wake_en;

    rx_state_e rx_state_q;
    logic [11:0] idx_q;
    logic [47:0] da_q;
    logic [31:0] crc_q;
    logic [7:0] len_hi_q;
    logic [15:0] len_q;
    logic [15:0] cur_len;
    logic rx_end;
    logic cut_now;
    logic addr_pass;
    logic is_broadcast_disable;
    logic hash_hit;
    logic frame_ok;

    tx_state_e tx_state_q;
    logic [4:0] attempts_q;
    logic tx_give_up;
    logic tx_last_err_q;

    assign promisc = ctrl_q[BIT_PROMISC];
    assign accept_bad = ctrl_q[BIT_ACCEPT_BAD];
    assign broadcast_disable_dis = ctrl_q[BIT_BROADCAST_DISABLE_DIS];
    assign retry_dis = ctrl_q[BIT_RETRY_DIS];
    assign pad_strip = ctrl_q[BIT_PAD_STRIP];
    assign wake_en = wake_q[BIT_WAKE_EN];

    // Register writes; reserved bits stay zero.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_q <= CTRL_RST;
            addr_hi_q <= ZERO_RST;
            addr_lo_q <= ZERO_RST;
            hash_hi_q <= ZERO_RST;
            hash_lo_q <= ZERO_RST;
            wake_q <= ZERO_RST;
            int_mask_q <= '0;
        end else if (wr_i) begin
            case (addr_i)
                OFF_CTRL: ctrl_q <= wr_data_i & CTRL_WMASK;
                OFF_ADDR_HI: addr_hi_q <= wr_data_i & ADDR_HI_WMASK;
                OFF_ADDR_LO: addr_lo_q <= wr_data_i;
                OFF_HASH_HI: hash_hi_q <= wr_data_i;
                OFF_HASH_LO: hash_lo_q <= wr_data_i;
                OFF_WAKE: wake_q <= wr_data_i & WAKE_WMASK;
                OFF_INT_MASK: int_mask_q <= wr_data_i[INT_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // Read mux; unmapped offsets read zero.
    always_comb begin
        case (addr_i)
            OFF_CTRL: rd_data_d = ctrl_q;
            OFF_ADDR_HI: rd_data_d = addr_hi_q;
            OFF_ADDR_LO: rd_data_d = addr_lo_q;
            OFF_HASH_HI: rd_data_d = hash_hi_q;
            OFF_HASH_LO: rd_data_d = hash_lo_q;
            OFF_WAKE: rd_data_d = wake_q;
            OFF_INT_STAT: rd_data_d = {29'h0, int_stat_q};
            OFF_INT_MASK: rd_data_d = {29'h0, int_mask_q};
            OFF_TX_STAT: rd_data_d = {26'h0, tx_last_err_q, attempts_q};
            default: rd_data_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_o <= 32'h0000_0000;
        end else begin
            rd_data_o <= rd_i ? rd_data_d : 32'h0000_0000;
        end
    end

    // Sticky interrupt status; a new event wins over a clear.
    assign int_clr = (wr_i && addr_i == OFF_INT_STAT) ?
                     wr_data_i[INT_W-1:0] : '0;
    assign int_evt[INT_RX_ACCEPT] = rx_end & frame_ok;
    assign int_evt[INT_RX_REJECT] = rx_end & ~frame_ok;
    assign int_evt[INT_TX_RETRY_ERR] = tx_give_up;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            int_stat_q <= '0;
        end else begin
            int_stat_q <= (int_stat_q & ~int_clr) | int_evt;
        end
    end

    assign irq_o = |(int_stat_q & int_mask_q);

    // Address checker.
    addr_check u_addr_check (
        .dest_addr_i(da_q),
        .hash_idx_i(crc_q[31:26]),
        .station_addr_i({addr_hi_q[15:0], addr_lo_q}),
        .hash_table_i({hash_hi_q, hash_lo_q}),
        .hash_perfect_select_i(ctrl_q[BIT_HASH_PERF]),
        .hash_only_filter_i(ctrl_q[BIT_HASH_ONLY]),
        .addr_pass_o(addr_pass),
        .is_broadcast_disable_o(is_broadcast_disable),
        .hash_hit_o(hash_hit)
    );

    assign rx_end = rx_valid_i & rx_last_i;

    // Final acceptance of a frame at its last byte.
    always_comb begin
        if (rx_bad_i && !accept_bad) begin
            frame_ok = 1'b0;
        end else if (promisc) begin
            frame_ok = 1'b1;
        end else if (is_broadcast_disable) begin
            frame_ok = ~broadcast_disable_dis | (wake_en & rx_wakeup_i);
        end else begin
            frame_ok = addr_pass;
        end
    end

    // Byte index, destination capture, hash and length field.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            idx_q <= 12'h000;
            da_q <= 48'h0000_0000_0000;
            crc_q <= CRC_INIT;
            len_hi_q <= 8'h00;
            len_q <= 16'h0000;
        end else if (rx_valid_i) begin
            if (rx_last_i) begin
                idx_q <= 12'h000;
                crc_q <= CRC_INIT;
            end else begin
                idx_q <= (idx_q == IDX_MAX) ? idx_q : idx_q + 12'h001;
                if (idx_q < DA_BYTES) begin
                    da_q <= {rx_data_i, da_q[47:8]};
                    crc_q <= crc32_byte(crc_q, rx_data_i);
                end
            end
            if (idx_q == LEN_HI_IDX) begin
                len_hi_q <= rx_data_i;
            end
            if (idx_q == LEN_LO_IDX) begin
                len_q <= {len_hi_q, rx_data_i};
            end
        end
    end

    // Cut point: last byte of header plus the stated data length.
    assign cur_len = (idx_q == LEN_LO_IDX) ? {len_hi_q, rx_data_i} : len_q;
    assign cut_now = pad_strip && idx_q >= LEN_LO_IDX && cur_len < MIN_LEN
                     && {4'h0, idx_q} == 16'(cur_len + 16'(LEN_LO_IDX));

    // Delivery state: pass bytes, or swallow pad and FCS after the cut.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_state_q <= RX_PASS;
        end else begin
            case (rx_state_q)
                RX_PASS: begin
                    if (rx_valid_i && cut_now && !rx_last_i) begin
                        rx_state_q <= RX_TRIM;
                    end
                end
                RX_TRIM: begin
                    if (rx_end) begin
                        rx_state_q <= RX_PASS;
                    end
                end
                default: rx_state_q <= RX_PASS;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_out_valid_o <= 1'b0;
            rx_out_data_o <= 8'h00;
            rx_out_last_o <= 1'b0;
        end else begin
            rx_out_valid_o <= rx_valid_i && rx_state_q == RX_PASS;
            rx_out_data_o <= rx_data_i;
            rx_out_last_o <= rx_valid_i && rx_state_q == RX_PASS
                             && (rx_last_i || cut_now);
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_frame_done_o <= 1'b0;
            rx_frame_accept_o <= 1'b0;
        end else begin
            rx_frame_done_o <= rx_end;
            rx_frame_accept_o <= rx_end & frame_ok;
        end
    end

    // Transmit attempts: retry until the limit, or give up at once.
    assign tx_give_up = tx_state_q == TX_ACTIVE && tx_collision_i
                        && (retry_dis || attempts_q == MAX_ATTEMPTS);

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_state_q <= TX_IDLE;
            attempts_q <= 5'h00;
        end else begin
            case (tx_state_q)
                TX_IDLE: begin
                    if (tx_start_i) begin
                        tx_state_q <= TX_ACTIVE;
                        attempts_q <= 5'h01;
                    end
                end
                TX_ACTIVE: begin
                    if (tx_give_up || tx_success_i) begin
                        tx_state_q <= TX_IDLE;
                    end else if (tx_collision_i) begin
                        attempts_q <= attempts_q + 5'h01;
                    end
                end
                default: tx_state_q <= TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_retry_o <= 1'b0;
            tx_abandon_o <= 1'b0;
            tx_retry_err_o <= 1'b0;
            tx_last_err_q <= 1'b0;
        end else begin
            tx_retry_o <= tx_state_q == TX_ACTIVE && tx_collision_i
                          && !tx_give_up;
            tx_abandon_o <= tx_give_up;
            tx_retry_err_o <= tx_give_up;
            if (tx_give_up) begin
                tx_last_err_q <= 1'b1;
            end else if (tx_state_q == TX_IDLE && tx_start_i) begin
                tx_last_err_q <= 1'b0;
            end
        end
    end

    // Checks.
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    a_bad_reject: assert property (
        rx_end && rx_bad_i && !accept_bad
        |=> rx_frame_done_o && !rx_frame_accept_o)
        else $error("bad frame accepted");
    a_bad_pass: assert property (
        rx_end && rx_bad_i && accept_bad && addr_pass && !is_broadcast_disable
        |=> rx_frame_accept_o)
        else $error("bad frame dropped");
    a_hash_only_miss: assert property (
        rx_end && ctrl_q[BIT_HASH_ONLY] && !promisc && !is_broadcast_disable
        && !hash_hit |=> !rx_frame_accept_o)
        else $error("hash miss accepted");
    a_perfect_miss: assert property (
        rx_end && !ctrl_q[BIT_HASH_PERF] && !ctrl_q[BIT_HASH_ONLY]
        && !promisc && !is_broadcast_disable && da_q != {addr_hi_q[15:0], addr_lo_q}
        |=> !rx_frame_accept_o)
        else $error("perfect miss accepted");
    a_mcast_hash: assert property (
        rx_end && ctrl_q[BIT_HASH_PERF] && da_q[0] && !is_broadcast_disable
        && hash_hit && !rx_bad_i |=> rx_frame_accept_o)
        else $error("multicast hash hit dropped");
    a_ia_perfect: assert property (
        rx_end && ctrl_q[BIT_HASH_PERF] && !ctrl_q[BIT_HASH_ONLY]
        && !da_q[0] && da_q == {addr_hi_q[15:0], addr_lo_q} && !rx_bad_i
        |=> rx_frame_accept_o)
        else $error("individual match dropped");
    a_broadcast_disable_block: assert property (
        rx_end && is_broadcast_disable && broadcast_disable_dis && !promisc
        && !(wake_en && rx_wakeup_i) |=> !rx_frame_accept_o)
        else $error("broadcast passed while disabled");
    a_broadcast_disable_wake: assert property (
        rx_end && is_broadcast_disable && wake_en && rx_wakeup_i && !rx_bad_i
        |=> rx_frame_accept_o)
        else $error("wake-up broadcast dropped");
    a_single_try: assert property (
        tx_state_q == TX_ACTIVE && tx_collision_i && retry_dis
        |=> tx_abandon_o && tx_retry_err_o && !tx_retry_o ##1 !tx_abandon_o)
        else $error("retry made while disabled");
    a_sixteen_tries: assert property (
        tx_state_q == TX_ACTIVE && tx_collision_i && !retry_dis
        |=> (tx_retry_o == ($past(attempts_q) < MAX_ATTEMPTS))
        && (tx_retry_err_o == ($past(attempts_q) == MAX_ATTEMPTS)))
        else $error("retry limit wrong");
    a_pad_cut: assert property (
        rx_valid_i && !rx_last_i && cut_now && rx_state_q == RX_PASS
        |=> rx_out_last_o ##1 !rx_out_valid_o)
        else $error("short frame not trimmed");
    a_long_kept: assert property (
        rx_valid_i && idx_q > LEN_LO_IDX && len_q >= MIN_LEN
        && rx_state_q == RX_PASS |=> rx_out_valid_o)
        else $error("long frame byte lost");
    a_no_strip: assert property (
        rx_valid_i && !pad_strip && rx_state_q == RX_PASS
        |=> rx_out_valid_o && rx_out_data_o == $past(rx_data_i)
        && rx_out_last_o == $past(rx_last_i))
        else $error("frame modified with strip off");
    a_promisc_all: assert property (
        rx_end && promisc && !rx_bad_i |=> rx_frame_accept_o)
        else $error("promiscuous frame dropped");
    a_ctrl_reserved: assert property (
        rd_i && addr_i == OFF_CTRL |=> (rd_data_o & ~CTRL_WMASK) == 32'h0)
        else $error("reserved control bit set");

    c_trimmed: cover property (rx_out_last_o && rx_state_q == RX_TRIM);
    c_hash_accept: cover property (
        rx_end && ctrl_q[BIT_HASH_PERF] && frame_ok);
    c_retry_limit: cover property (tx_give_up && !retry_dis);
    c_irq: cover property (irq_o);

endmodule : mac_rx_tx_ctrl

// ### test/fabric_port_model.sv
// Fabric port model that sends receive frames and answers transmit attempts.
`timescale 1ns/10ps
module fabric_port_model (
    // Clock.
    input wire logic mclk_i,
    // Receive stream.
    output logic rx_valid_o,
    output logic [7:0] rx_data_o,
    output logic rx_last_o,
    output logic rx_bad_o,
    output logic rx_wakeup_o,
    // Transmit attempt results.
    output logic tx_start_o,
    output logic tx_collision_o,
    output logic tx_success_o
);
    initial begin
        rx_valid_o = 1'b0;
        rx_data_o = 8'h00;
        rx_last_o = 1'b0;
        rx_bad_o = 1'b0;
        rx_wakeup_o = 1'b0;
        tx_start_o = 1'b0;
        tx_collision_o = 1'b0;
        tx_success_o = 1'b0;
    end

    // Sends a frame; between frames the data line shows the inverted byte.
    task automatic send_frame(input logic [47:0] da, input logic [15:0] len,
                              input int n, input logic bad, input logic wk);
        logic [7:0] b;
        b = 8'h00;
        for (int i = 0; i < n; i++) begin
            if (i < 6) begin
                b = da[8*i +: 8];
            end else if (i == 12) begin
                b = len[15:8];
            end else if (i == 13) begin
                b = len[7:0];
            end else begin
                b = 8'(i);
            end
            @(posedge mclk_i);
            rx_valid_o <= 1'b1;
            rx_data_o <= b;
            rx_last_o <= (i == n - 1);
            rx_bad_o <= bad & (i == n - 1);
            rx_wakeup_o <= wk & (i == n - 1);
        end
        @(posedge mclk_i);
        rx_valid_o <= 1'b0;
        rx_last_o <= 1'b0;
        rx_bad_o <= 1'b0;
        rx_wakeup_o <= 1'b0;
        rx_data_o <= ~b;
    endtask : send_frame

    // Pulses start, collision or success for one cycle.
    task automatic tx_event(input int kind);
        @(posedge mclk_i);
        tx_start_o <= (kind == 0);
        tx_collision_o <= (kind == 1);
        tx_success_o <= (kind == 2);
        @(posedge mclk_i);
        tx_start_o <= 1'b0;
        tx_collision_o <= 1'b0;
        tx_success_o <= 1'b0;
    endtask : tx_event
endmodule : fabric_port_model

// ### test/mac_rx_tx_ctrl_tb.sv
// Self-checking testbench for the receive filter and retry control.
`timescale 1ns/10ps
module mac_rx_tx_ctrl_tb;
    import mac_ctrl_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wr_data_i = 32'h0000_0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [31:0] rd_data_o;
    logic rx_valid_i, rx_last_i, rx_bad_i, rx_wakeup_i;
    logic [7:0] rx_data_i, rx_out_data_o;
    logic rx_out_valid_o, rx_out_last_o, rx_frame_done_o, rx_frame_accept_o;
    logic tx_start_i, tx_collision_i, tx_success_i;
    logic tx_retry_o, tx_abandon_o, tx_retry_err_o, irq_o;
    int errors = 0;
    int samples_checked = 0;
    int nout = 0;
    int nretry = 0;
    int nabandon = 0;
    int nerr = 0;
    int nlast = 0;
    logic [7:0] lastb;
    logic acc;
    localparam logic [47:0] STA = 48'h5544_3322_1100;
    localparam logic [47:0] OTHER = 48'h5544_3322_1102;
    localparam logic [47:0] MCAST = 48'h5544_3322_1101;
    localparam logic [47:0] BROADCAST_DISABLE = 48'hFFFF_FFFF_FFFF;

    always #4 mclk_i = ~mclk_i;

    mac_rx_tx_ctrl dut (.mclk_i, .rst_n_i, .addr_i, .wr_data_i, .wr_i, .rd_i,
        .rd_data_o, .rx_valid_i, .rx_data_i, .rx_last_i, .rx_bad_i,
        .rx_wakeup_i, .rx_out_valid_o, .rx_out_data_o, .rx_out_last_o,
        .rx_frame_done_o, .rx_frame_accept_o, .tx_start_i, .tx_collision_i,
        .tx_success_i, .tx_retry_o, .tx_abandon_o, .tx_retry_err_o, .irq_o);

    fabric_port_model fab (.mclk_i, .rx_valid_o(rx_valid_i),
        .rx_data_o(rx_data_i), .rx_last_o(rx_last_i), .rx_bad_o(rx_bad_i),
        .rx_wakeup_o(rx_wakeup_i), .tx_start_o(tx_start_i),
        .tx_collision_o(tx_collision_i), .tx_success_o(tx_success_i));

    // Counts delivered bytes and transmit pulses, and keeps the verdict.
    always @(posedge mclk_i) begin
        if (rx_out_valid_o === 1'b1) nout++;
        if (rx_out_last_o === 1'b1) begin
            nlast++;
            lastb = rx_out_data_o;
        end
        if (rx_frame_done_o === 1'b1) acc = rx_frame_accept_o;
        if (tx_retry_o === 1'b1) nretry++;
        if (tx_abandon_o === 1'b1) nabandon++;
        if (tx_retry_err_o === 1'b1) nerr++;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask : reg_wr

    task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 check(rd_data_o, exp);
    endtask : rd_check

    // Sends a frame and checks acceptance and, if given, the byte count.
    task automatic frame(input logic [47:0] da, input logic [15:0] len,
                         input int n, input logic bad, input logic wk,
                         input logic exp_acc, input int exp_n);
        nout = 0;
        nlast = 0;
        lastb = 8'hXX;
        acc = 1'bx;
        fab.send_frame(da, len, n, bad, wk);
        repeat (2) @(posedge mclk_i);
        #1 check({31'h0, acc}, {31'h0, exp_acc});
        if (exp_n >= 0) begin
            check(32'(nout), 32'(exp_n));
            check(32'(nlast), 32'h0000_0001);
            check({24'h0, lastb}, {24'h0, 8'(exp_n - 1)});
        end
    endtask : frame

    task automatic tx_run(input logic [31:0] ctrl, input int ncol);
        reg_wr(OFF_CTRL, ctrl);
        nretry = 0;
        nabandon = 0;
        nerr = 0;
        fab.tx_event(0);
        repeat (ncol) fab.tx_event(1);
        repeat (2) @(posedge mclk_i);
    endtask : tx_run

    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict

    initial begin
        #400000;
        errors++;
        give_verdict;
    end

    initial begin
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        rd_check(OFF_CTRL, 32'h0004_0000);
        frame(OTHER, 16'h0040, 64, 1'b0, 1'b0, 1'b1, 64);
        reg_wr(OFF_CTRL, 32'hFFFF_FFFF);
        rd_check(OFF_CTRL, 32'h0005_AD00);
        rd_check(8'hFC, 32'h0000_0000);
        reg_wr(OFF_CTRL, 32'h0000_0000);
        rd_check(OFF_CTRL, 32'h0000_0000);
        reg_wr(OFF_ADDR_LO, STA[31:0]);
        reg_wr(OFF_ADDR_HI, {16'h0000, STA[47:32]});
        reg_wr(OFF_INT_MASK, 32'h0000_0001);
        frame(STA, 16'h0040, 64, 1'b0, 1'b0, 1'b1, 64);
        frame(OTHER, 16'h0040, 64, 1'b0, 1'b0, 1'b0, -1);
        frame(MCAST, 16'h0040, 64, 1'b0, 1'b0, 1'b0, -1);
        frame(BROADCAST_DISABLE, 16'h0040, 64, 1'b0, 1'b0, 1'b1, 64);
        reg_wr(OFF_CTRL, 32'h0000_0800);
        frame(BROADCAST_DISABLE, 16'h0040, 64, 1'b0, 1'b0, 1'b0, -1);
        reg_wr(OFF_WAKE, 32'h0000_0001);
        frame(BROADCAST_DISABLE, 16'h0040, 64, 1'b0, 1'b1, 1'b1, -1);
        reg_wr(OFF_CTRL, 32'h0000_0000);
        frame(STA, 16'h0040, 20, 1'b1, 1'b0, 1'b0, -1);
        reg_wr(OFF_CTRL, 32'h0001_0000);
        frame(STA, 16'h0040, 20, 1'b1, 1'b0, 1'b1, 20);
        // An all-ones hash table passes every hashed address.
        reg_wr(OFF_HASH_HI, 32'hFFFF_FFFF);
        reg_wr(OFF_HASH_LO, 32'hFFFF_FFFF);
        reg_wr(OFF_CTRL, 32'h0000_2000);
        frame(MCAST, 16'h0040, 64, 1'b0, 1'b0, 1'b1, -1);
        frame(OTHER, 16'h0040, 64, 1'b0, 1'b0, 1'b0, -1);
        reg_wr(OFF_CTRL, 32'h0000_A000);
        frame(OTHER, 16'h0040, 64, 1'b0, 1'b0, 1'b1, -1);
        reg_wr(OFF_CTRL, 32'h0000_8000);
        frame(OTHER, 16'h0040, 64, 1'b0, 1'b0, 1'b1, -1);
        reg_wr(OFF_HASH_HI, 32'h0000_0000);
        reg_wr(OFF_HASH_LO, 32'h0000_0000);
        frame(MCAST, 16'h0040, 64, 1'b0, 1'b0, 1'b0, -1);
        frame(STA, 16'h0040, 64, 1'b0, 1'b0, 1'b0, -1);
        reg_wr(OFF_CTRL, 32'h0000_0100);
        frame(STA, 16'h0004, 64, 1'b0, 1'b0, 1'b1, 18);
        frame(STA, 16'h002D, 64, 1'b0, 1'b0, 1'b1, 59);
        frame(STA, 16'h002E, 64, 1'b0, 1'b0, 1'b1, 64);
        reg_wr(OFF_CTRL, 32'h0000_0000);
        frame(STA, 16'h0004, 64, 1'b0, 1'b0, 1'b1, 64);
        check({31'h0, irq_o}, 32'h0000_0001);
        reg_wr(OFF_INT_STAT, 32'h0000_0007);
        #1 check({31'h0, irq_o}, 32'h0000_0000);
        rd_check(OFF_INT_STAT, 32'h0000_0000);
        tx_run(32'h0000_0400, 1);
        check(32'(nretry), 32'h0);
        check(32'({nabandon[0], nerr[0]}), 32'h3);
        rd_check(OFF_TX_STAT, 32'h0000_0021);
        check({31'h0, irq_o}, 32'h0000_0000);
        tx_run(32'h0000_0000, 16);
        check(32'(nretry), 32'h0000_000F);
        check(32'(nabandon + nerr), 32'h2);
        rd_check(OFF_TX_STAT, 32'h0000_0030);
        reg_wr(OFF_INT_MASK, 32'h0000_0004);
        #1 check({31'h0, irq_o}, 32'h0000_0001);
        give_verdict;
    end
endmodule : mac_rx_tx_ctrl_tb
